// ### pucs_pkg.sv
// Purpose: shared constants and types for the user configuration block
// Assumes: 200 MHz system clock, synchronous active-high reset
// Notes: rule summary follows
// Operation
// - two-bit transmission mode selects four modes
// - filter field picks 3-pole, 4-pole or reserved
// - slot field counts half-microsecond steps from sync
// - zero slot means default or free-running
// - second slot only for double-rate and hi-res
// - extension off sends zeros in D27-D32
// - direction code maps onto phase-2 nibble
// - four-bit revision sent in 10-bit length
// - year code plus nine gives Julian year
// - month and day codes pass through unchanged
// - manufacturing info sent only in 10-bit length
// - spare bits stored, readable, otherwise unused
// - status read-only, bits 7,5,0 read zero
// - test flag reads zero while test active
// - user array flag cleared on mismatch, sticky
// - check runs over shadows once lock set
package pucs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_IDENT = 8'h09;
  localparam logic [7:0] ADDR_DATE = 8'h0a;
  localparam logic [7:0] ADDR_DAY = 8'h0b;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions inside the ident byte
  localparam int EXT_BIT = 7;
  localparam int FREE_RUN_BIT = 6;
  // status bit positions
  localparam int ST_TEST_N = 6;
  localparam int ST_USER_OK = 4;
  localparam int ST_OC_DONE = 3;
  localparam int ST_FACT_OK = 2;
  localparam int ST_OFFS_OK = 1;
  localparam logic [7:0] STATUS_ZERO = 8'h00;
  // transmission modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_DOUBLE = 2'b01,
    MODE_HIRES = 2'b10,
    MODE_DAISY = 2'b11
  } pucs_mode_t;
  // filter choices
  typedef enum logic [1:0] {
    FILT_3POLE = 2'b00,
    FILT_4POLE = 2'b01,
    FILT_RSVD2 = 2'b10,
    FILT_RSVD3 = 2'b11
  } pucs_filter_t;
  // direction nibbles
  localparam logic [3:0] DIR_NIB_0 = 4'h0;
  localparam logic [3:0] DIR_NIB_1 = 4'h4;
  localparam logic [3:0] DIR_NIB_2 = 4'h8;
  localparam logic [3:0] DIR_NIB_3 = 4'hc;
  localparam logic [6:0] YEAR_OFFSET = 7'h09;
  // slot timing: unit in ps, clock period in ps
  localparam int SLOT_UNIT_PS = 500000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam logic [16:0] SLOT_UNIT_CYC = 17'(SLOT_UNIT_PS / CLK_PERIOD_PS);
  // error code: x^3+x+1, seed 111, 63 bits checked
  localparam logic [2:0] CODE_SEED = 3'h7;
  localparam int CODE_BITS = 63;
endpackage

// ### pucs_link_if.sv
// Purpose: carrier between the register core, decoder and checker
// Assumes: one clock domain, all signals combinational levels
// Notes: core drives stored bytes, leaves return decoded values
`timescale 1ns/1ps
`default_nettype none
interface pucs_link_if;
  logic [7:0] ident_byte;
  logic [7:0] date_byte;
  logic [7:0] day_byte;
  logic [7:0] mode_byte;
  logic [7:0] slot_a_lo;
  logic [7:0] slot_b_lo;
  logic short_data;
  logic [16:0] slot_a_cyc;
  logic slot_a_dflt;
  logic free_run;
  logic [16:0] slot_b_cyc;
  logic slot_b_used;
  logic [3:0] dir_nib;
  logic [6:0] julian_year;
  logic [62:0] check_bits;
  logic [2:0] calc_code;
  modport core (output ident_byte, date_byte, day_byte, mode_byte,
    slot_a_lo, slot_b_lo, short_data, check_bits,
    input slot_a_cyc, slot_a_dflt, free_run, slot_b_cyc, slot_b_used,
    dir_nib, julian_year, calc_code);
  modport dec (input ident_byte, date_byte, day_byte, mode_byte,
    slot_a_lo, slot_b_lo, short_data,
    output slot_a_cyc, slot_a_dflt, free_run, slot_b_cyc, slot_b_used,
    dir_nib, julian_year);
  modport chk (input check_bits, output calc_code);
endinterface
`default_nettype wire

// ### pucs_decode.sv
// Purpose: decode slot, direction and date fields
// Assumes: inputs stable levels from the core
// Notes: purely combinational, the core registers every result
`timescale 1ns/1ps
`default_nettype none
module pucs_decode (
  pucs_link_if.dec lnk
);
  import pucs_pkg::*;
  // slot field to clock cycles; zero stays zero for default handling
  function automatic logic [16:0] slot_cycles(input logic [9:0] f);
    slot_cycles = 17'(17'(f) * SLOT_UNIT_CYC);
  endfunction
  logic [9:0] fa;
  logic [9:0] fb;
  pucs_mode_t md;
  // field extraction and decode
  always_comb begin
    fa = {lnk.mode_byte[1:0], lnk.slot_a_lo};
    fb = {lnk.mode_byte[3:2], lnk.slot_b_lo};
    md = pucs_mode_t'(lnk.mode_byte[7:6]);
    lnk.slot_a_cyc = slot_cycles(fa);
    // zero field: free_running_enable bit picks default or free-running
    lnk.slot_a_dflt = (fa == 10'h000) && !lnk.ident_byte[FREE_RUN_BIT];
    lnk.free_run = (fa == 10'h000) && lnk.ident_byte[FREE_RUN_BIT];
    // second slot ignored outside double-rate and hi-res
    lnk.slot_b_used = (md == MODE_DOUBLE) || (md == MODE_HIRES);
    lnk.slot_b_cyc = lnk.slot_b_used ? slot_cycles(fb) : 17'h00000;
    case (lnk.ident_byte[5:4])
      2'b00: lnk.dir_nib = DIR_NIB_0;
      2'b01: lnk.dir_nib = DIR_NIB_1;
      2'b10: lnk.dir_nib = DIR_NIB_2;
      default: lnk.dir_nib = DIR_NIB_3;
    endcase
    lnk.julian_year = 7'(7'(lnk.date_byte[3:0]) + YEAR_OFFSET);
  end
endmodule
`default_nettype wire

// ### pucs_check.sv
// Purpose: serial-equivalent error code over the user shadow bits
// Assumes: bit 0 of check_bits is fed first
// Notes: unrolled in a generate chain, settles within one cycle
`timescale 1ns/1ps
`default_nettype none
module pucs_check (
  pucs_link_if.chk lnk
);
  import pucs_pkg::*;
  logic [2:0] stage [0:CODE_BITS];
  assign stage[0] = CODE_SEED;
  // one lfsr step per bit, lsb first
  genvar i;
  generate
    for (i = 0; i < CODE_BITS; i++) begin : g_step
      logic fb;
      assign fb = lnk.check_bits[i] ^ stage[i][2];
      assign stage[i+1] = {stage[i][1], stage[i][0] ^ fb, fb};
    end
  endgenerate
  assign lnk.calc_code = stage[CODE_BITS];
endmodule
`default_nettype wire

// ### pucs_top.sv
// Purpose: user config shadows, phase-2 data and status register
// Assumes: register port is the programming-mode access path
// Notes: writes are refused once the user array is locked
`timescale 1ns/1ps
`default_nettype none
module pucs_top (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic user_lock_in,
  input wire logic short_data_in,
  input wire logic [7:0] lock_ctrl_byte_in,
  input wire logic [7:0] mode_filter_byte_in,
  input wire logic [7:0] slot_a_low_byte_in,
  input wire logic [7:0] slot_b_low_byte_in,
  input wire logic [7:0] maker_id_byte_in,
  input wire logic [2:0] stored_user_code_in,
  input wire logic test_mode_in,
  input wire logic offset_init_done_in,
  input wire logic factory_array_ok_in,
  input wire logic offset_ok_in,
  input wire logic [23:0] ext_content_in,
  output var pucs_pkg::pucs_mode_t transmission_mode_sel_out,
  output var pucs_pkg::pucs_filter_t filter_select_out,
  output logic filter_reserved_out,
  output logic [16:0] first_slot_time_out,
  output logic default_slot_delay_out,
  output logic free_running_enable_out,
  output logic [16:0] second_slot_time_out,
  output logic second_slot_used_out,
  output logic [23:0] phase2_ext_out,
  output logic [3:0] direction_nibble_out,
  output logic [3:0] revision_out,
  output logic [6:0] julian_year_code_out,
  output logic [3:0] julian_month_code_out,
  output logic [4:0] julian_day_code_out,
  output logic user_array_ok_n_out
);
  import pucs_pkg::*;

  pucs_link_if lnk ();

  logic [7:0] ident_q, ident_d;
  logic [7:0] date_q, date_d;
  logic [7:0] day_q, day_d;
  logic ok_q, ok_d;
  logic [7:0] rd_q, rd_d;
  logic rdv_q, rdv_d;
  logic [7:0] status_v;
  logic mismatch;
  logic wr_ok;
  pucs_mode_t mode_d;
  pucs_filter_t filt_d;
  logic rsv_d, dflt_d, free_d, used_d;
  logic [16:0] slota_d, slotb_d;
  logic [23:0] ext_d;
  logic [3:0] dir_d, rev_d, month_d;
  logic [6:0] year_d;
  logic [4:0] dnum_d;

  pucs_decode pucs_decode_inst (
    .lnk(lnk)
  );
  pucs_check pucs_check_inst (
    .lnk(lnk)
  );

  // drive the carrier from shadows and configuration inputs
  assign lnk.ident_byte = ident_q;
  assign lnk.date_byte = date_q;
  assign lnk.day_byte = day_q;
  assign lnk.mode_byte = mode_filter_byte_in;
  assign lnk.slot_a_lo = slot_a_low_byte_in;
  assign lnk.slot_b_lo = slot_b_low_byte_in;
  assign lnk.short_data = short_data_in;
  // lsb first, lower addresses first; lock bit left out
  assign lnk.check_bits = {maker_id_byte_in, day_q, date_q, ident_q,
    slot_b_low_byte_in, slot_a_low_byte_in, mode_filter_byte_in,
    lock_ctrl_byte_in[6:0]};
  // check compares only while the array is locked
  assign mismatch = user_lock_in && (lnk.calc_code != stored_user_code_in);
  // locked arrays refuse further programming
  assign wr_ok = wr_en_in && !user_lock_in;

  // status assembly; bits 7, 5 and 0 are hard zero
  always_comb begin
    status_v = STATUS_ZERO;
    status_v[ST_TEST_N] = !test_mode_in;
    status_v[ST_USER_OK] = ok_q;
    status_v[ST_OC_DONE] = offset_init_done_in;
    status_v[ST_FACT_OK] = factory_array_ok_in;
    status_v[ST_OFFS_OK] = offset_ok_in;
  end

  // shadow writes; spare bits stored as-is and read back
  always_comb begin
    ident_d = ident_q;
    date_d = date_q;
    day_d = day_q;
    if (wr_ok) begin
      case (addr_in)
        ADDR_IDENT: ident_d = wr_data_in;
        ADDR_DATE: date_d = wr_data_in;
        ADDR_DAY: day_d = wr_data_in;
        // status and unmapped writes have no effect
        default: ident_d = ident_q;
      endcase
    end
  end

  // user array flag: only reset brings it back
  always_comb begin
    ok_d = ok_q;
    if (mismatch) begin
      ok_d = 1'b0;
    end
  end

  // read path; unmapped offsets read zero
  always_comb begin
    rdv_d = rd_en_in;
    rd_d = 8'h00;
    if (rd_en_in) begin
      case (addr_in)
        ADDR_IDENT: rd_d = ident_q;
        ADDR_DATE: rd_d = date_q;
        ADDR_DAY: rd_d = day_q;
        ADDR_STATUS: rd_d = status_v;
        default: rd_d = 8'h00;
      endcase
    end
  end

  // register state
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ident_q <= REG_RESET;
      date_q <= REG_RESET;
      day_q <= REG_RESET;
      ok_q <= 1'b1;
      rd_q <= 8'h00;
      rdv_q <= 1'b0;
    end else begin
      ident_q <= ident_d;
      date_q <= date_d;
      day_q <= day_d;
      ok_q <= ok_d;
      rd_q <= rd_d;
      rdv_q <= rdv_d;
    end
  end

  // decoded phase-2 and timing values, registered below
  always_comb begin
    mode_d = pucs_mode_t'(mode_filter_byte_in[7:6]);
    filt_d = pucs_filter_t'(mode_filter_byte_in[5:4]);
    rsv_d = mode_filter_byte_in[5];
    slota_d = lnk.slot_a_cyc;
    dflt_d = lnk.slot_a_dflt;
    free_d = lnk.free_run;
    slotb_d = lnk.slot_b_cyc;
    used_d = lnk.slot_b_used;
    // extension fields forced to zero when disabled
    ext_d = ident_q[EXT_BIT] ? ext_content_in : 24'h000000;
    // manufacturing data only in 10-bit length
    dir_d = 4'h0;
    rev_d = 4'h0;
    year_d = 7'h00;
    month_d = 4'h0;
    dnum_d = 5'h00;
    if (!short_data_in) begin
      dir_d = lnk.dir_nib;
      rev_d = ident_q[3:0];
      year_d = lnk.julian_year;
      month_d = date_q[7:4];
      dnum_d = day_q[4:0];
    end
  end

  // registered decoded outputs; one cycle behind the shadows
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      transmission_mode_sel_out <= MODE_NORMAL;
      filter_select_out <= FILT_3POLE;
      filter_reserved_out <= 1'b0;
      first_slot_time_out <= 17'h00000;
      default_slot_delay_out <= 1'b1;
      free_running_enable_out <= 1'b0;
      second_slot_time_out <= 17'h00000;
      second_slot_used_out <= 1'b0;
      phase2_ext_out <= 24'h000000;
      direction_nibble_out <= 4'h0;
      revision_out <= 4'h0;
      julian_year_code_out <= 7'h00;
      julian_month_code_out <= 4'h0;
      julian_day_code_out <= 5'h00;
    end else begin
      transmission_mode_sel_out <= mode_d;
      filter_select_out <= filt_d;
      filter_reserved_out <= rsv_d;
      first_slot_time_out <= slota_d;
      default_slot_delay_out <= dflt_d;
      free_running_enable_out <= free_d;
      second_slot_time_out <= slotb_d;
      second_slot_used_out <= used_d;
      phase2_ext_out <= ext_d;
      direction_nibble_out <= dir_d;
      revision_out <= rev_d;
      julian_year_code_out <= year_d;
      julian_month_code_out <= month_d;
      julian_day_code_out <= dnum_d;
    end
  end

  assign rd_data_out = rd_q;
  assign rd_valid_out = rdv_q;
  assign user_array_ok_n_out = ok_q;

  // checks kept beside the logic they guard
  property p_status_ro;
    @(posedge clk_sys_in) disable iff (srst_in)
    (wr_en_in && addr_in == ADDR_STATUS && !mismatch) |=> $stable(ok_q);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status write changed a flag");

  property p_zero_bits;
    @(posedge clk_sys_in) disable iff (srst_in)
    (rd_en_in && addr_in == ADDR_STATUS) |=>
      (rd_data_out[7] == 1'b0 && rd_data_out[5] == 1'b0 &&
       rd_data_out[0] == 1'b0 && rd_valid_out);
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("status fixed bits not zero");

  property p_test_flag;
    @(posedge clk_sys_in) disable iff (srst_in)
    (rd_en_in && addr_in == ADDR_STATUS) |=>
      rd_data_out[6] == !$past(test_mode_in);
  endproperty
  a_test_flag: assert property (p_test_flag)
    else $error("test flag polarity wrong");

  property p_sticky;
    @(posedge clk_sys_in) disable iff (srst_in)
    !user_array_ok_n_out |=> !user_array_ok_n_out [*3];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("user array flag recovered without reset");

  property p_clear;
    @(posedge clk_sys_in) disable iff (srst_in)
    (!srst_in && user_lock_in && lnk.calc_code != stored_user_code_in) |=>
      !user_array_ok_n_out;
  endproperty
  a_clear: assert property (p_clear)
    else $error("mismatch did not clear user array flag");

  property p_year;
    @(posedge clk_sys_in) disable iff (srst_in)
    (!srst_in && !short_data_in) |=>
      julian_year_code_out == 7'(7'($past(date_q[3:0])) + 7'h09);
  endproperty
  a_year: assert property (p_year)
    else $error("julian year offset wrong");

  property p_ext_off;
    @(posedge clk_sys_in) disable iff (srst_in)
    !ident_q[EXT_BIT] |=> phase2_ext_out == 24'h000000;
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("extension fields not zero");

  property p_slot_b;
    @(posedge clk_sys_in) disable iff (srst_in)
    (mode_filter_byte_in[7:6] == 2'b00 || mode_filter_byte_in[7:6] == 2'b11)
      |=> (!second_slot_used_out && second_slot_time_out == 17'h00000);
  endproperty
  a_slot_b: assert property (p_slot_b)
    else $error("second slot used in wrong mode");

  property p_slot_a;
    @(posedge clk_sys_in) disable iff (srst_in)
    (!srst_in &&
     {mode_filter_byte_in[1:0], slot_a_low_byte_in} == 10'h001) |=>
      (first_slot_time_out == 17'd100 && !default_slot_delay_out &&
       !free_running_enable_out);
  endproperty
  a_slot_a: assert property (p_slot_a)
    else $error("slot unit count wrong");

  property p_short;
    @(posedge clk_sys_in) disable iff (srst_in)
    short_data_in |=> (revision_out == 4'h0 && julian_day_code_out == 5'h00);
  endproperty
  a_short: assert property (p_short)
    else $error("manufacturing info sent in 8-bit length");

  property p_mode;
    @(posedge clk_sys_in) disable iff (srst_in)
    !srst_in |=>
      (transmission_mode_sel_out == $past(mode_filter_byte_in[7:6]) &&
       filter_select_out == $past(mode_filter_byte_in[5:4]));
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode or filter select not taken from its field");

  property p_dir_nib;
    @(posedge clk_sys_in) disable iff (srst_in)
    (!srst_in && !short_data_in) |=>
      direction_nibble_out == {$past(ident_q[5:4]), 2'b00};
  endproperty
  a_dir_nib: assert property (p_dir_nib)
    else $error("direction nibble mapping wrong");

  property p_date_pass;
    @(posedge clk_sys_in) disable iff (srst_in)
    (!srst_in && !short_data_in) |=>
      (julian_month_code_out == $past(date_q[7:4]) &&
       julian_day_code_out == $past(day_q[4:0]) &&
       revision_out == $past(ident_q[3:0]));
  endproperty
  a_date_pass: assert property (p_date_pass)
    else $error("month, day or revision not passed unchanged");
endmodule
`default_nettype wire

// ### pucs_ecu_model.sv
// Purpose: programming-side model that drives the register port
// Assumes: one request per call, strobe held for exactly one edge
// Notes: released write data is inverted so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module pucs_ecu_model (
  input wire logic clk_sys_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wr_data_out,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in
);
  // idle bus at time zero
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wr_data_out = 8'h00;
  end
  // one write; strobe, address and data for one edge, then data inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wr_data_out <= d;
    @(posedge clk_sys_in);
    wr_en_out <= 1'b0;
    wr_data_out <= ~d;
  endtask
  // one read; returns {valid, data} taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [8:0] v);
    @(posedge clk_sys_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_sys_in);
    rd_en_out <= 1'b0;
    #1;
    v = {rd_valid_in, rd_data_in};
  endtask
endmodule
`default_nettype wire

// ### psi5_user_config_status_tb_top.sv
// Purpose: self-checking bench for the user config and status block
// Assumes: 200 MHz clock, inputs changed by nonblocking at rising edge
// Notes: the matching error code is found by search, not recomputed
`timescale 1ns/1ps
`default_nettype none
module psi5_user_config_status_tb_top;
  import pucs_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic lock = 1'b0;
  logic short_len = 1'b0;
  logic test_mode = 1'b0;
  logic [2:0] flg = 3'h0;
  logic [2:0] code = 3'h0;
  logic [7:0] lb = 8'h5a;
  logic [7:0] mf = 8'h00;
  logic [7:0] sa = 8'h00;
  logic [7:0] sb = 8'h00;
  logic [7:0] mk = 8'h3c;
  logic [23:0] ext = 24'ha5c3e1;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic rvld;
  pucs_mode_t mode_o;
  pucs_filter_t filt_o;
  logic rsv_o;
  logic [16:0] slot_a;
  logic dflt;
  logic free;
  logic [16:0] slot_b;
  logic used;
  logic [23:0] p2ext;
  logic [3:0] dir;
  logic [3:0] rev;
  logic [6:0] yr;
  logic [3:0] mon;
  logic [4:0] dnum;
  logic ok_n;
  logic [8:0] v;
  int miscompares = 0;
  int samples_checked = 0;
  int hits;
  int good;

  // free-running clock, 5 ns period
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  pucs_ecu_model pucs_ecu_model_inst (.clk_sys_in(clk_sys_in),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
    .wr_data_out(wdat), .rd_data_in(rdat), .rd_valid_in(rvld));

  pucs_top pucs_top_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
    .wr_data_in(wdat), .rd_data_out(rdat), .rd_valid_out(rvld),
    .user_lock_in(lock), .short_data_in(short_len),
    .lock_ctrl_byte_in(lb), .mode_filter_byte_in(mf),
    .slot_a_low_byte_in(sa), .slot_b_low_byte_in(sb),
    .maker_id_byte_in(mk), .stored_user_code_in(code),
    .test_mode_in(test_mode), .offset_init_done_in(flg[2]),
    .factory_array_ok_in(flg[1]), .offset_ok_in(flg[0]),
    .ext_content_in(ext), .transmission_mode_sel_out(mode_o),
    .filter_select_out(filt_o), .filter_reserved_out(rsv_o),
    .first_slot_time_out(slot_a), .default_slot_delay_out(dflt),
    .free_running_enable_out(free), .second_slot_time_out(slot_b),
    .second_slot_used_out(used), .phase2_ext_out(p2ext),
    .direction_nibble_out(dir), .revision_out(rev),
    .julian_year_code_out(yr), .julian_month_code_out(mon),
    .julian_day_code_out(dnum), .user_array_ok_n_out(ok_n));

  // compare and count; four-state so an unknown never matches
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // decoded outputs lag a register write by two edges
  task automatic st;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
  endtask

  task automatic results;
    $display("checked %0d, wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // reset values of the three stored bytes and the idle decode
  task automatic t_reset;
    for (int i = 9; i < 12; i++) begin
      pucs_ecu_model_inst.rd(8'(i), v);
      chk(v, 9'h100);
    end
    chk(dflt, 1'b1);
    chk(ok_n, 1'b1);
    $display("reset test done");
  endtask

  // every mode and filter code, second slot use follows the mode
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 4; f++) begin
        @(posedge clk_sys_in);
        mf <= {m[1:0], f[1:0], 4'hf};
        sa <= 8'hff;
        sb <= 8'hff;
        st();
        chk(mode_o, m[1:0]);
        chk(filt_o, f[1:0]);
        chk(rsv_o, f[1]);
        chk(slot_a, 1023 * 100);
        chk(slot_b, (m == 1 || m == 2) ? 1023 * 100 : 0);
        chk(used, m == 1 || m == 2);
      end
    end
    $display("mode test done");
  endtask

  // smallest slot ignores the free_running_enable bit, zero slot obeys it
  task automatic t_slots;
    @(posedge clk_sys_in);
    mf <= 8'h00;
    sa <= 8'h01;
    pucs_ecu_model_inst.wr(ADDR_IDENT, 8'h40);
    st();
    chk(slot_a, 100);
    chk({dflt, free}, 2'b00);
    @(posedge clk_sys_in);
    sa <= 8'h00;
    for (int a = 0; a < 2; a++) begin
      pucs_ecu_model_inst.wr(ADDR_IDENT, {1'b0, a[0], 6'h00});
      st();
      chk({dflt, free}, {~a[0], a[0]});
    end
    $display("slot test done");
  endtask

  // direction, revision, extension, date and the 8-bit length blanking
  task automatic t_ident;
    for (int d = 0; d < 4; d++) begin
      pucs_ecu_model_inst.wr(ADDR_IDENT, {d[0], 1'b0, d[1:0], 4'h9 ^ 4'(d)});
      st();
      chk(dir, {d[1:0], 2'b00});
      chk(rev, 4'h9 ^ 4'(d));
      chk(p2ext, d[0] ? ext : 24'h0);
    end
    pucs_ecu_model_inst.wr(ADDR_DATE, 8'hc0);
    pucs_ecu_model_inst.wr(ADDR_DAY, 8'hbf);
    st();
    chk({yr, mon, dnum}, {7'h09, 4'hc, 5'h1f});
    pucs_ecu_model_inst.wr(ADDR_DATE, 8'h1f);
    pucs_ecu_model_inst.rd(ADDR_DAY, v);
    chk(v, 9'h1bf);
    st();
    chk({yr, mon, dnum}, {7'h18, 4'h1, 5'h1f});
    chk(slot_a, 0);
    @(posedge clk_sys_in);
    short_len <= 1'b1;
    st();
    chk({dir, rev, yr, mon, dnum}, 24'h0);
    @(posedge clk_sys_in);
    short_len <= 1'b0;
    $display("ident test done");
  endtask

  // status layout, polarity, refused write and unmapped read
  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      test_mode <= i[0];
      flg <= 3'(i * 3 + 2);
      if (i == 3) pucs_ecu_model_inst.wr(ADDR_STATUS, 8'hff);
      pucs_ecu_model_inst.rd(ADDR_STATUS, v);
      chk(v, {1'b1, 1'b0, ~i[0], 2'b01, 3'(i * 3 + 2), 1'b0});
    end
    pucs_ecu_model_inst.rd(8'h00, v);
    chk(v, 9'h100);
    $display("status test done");
  endtask

  // exactly one stored code matches; mismatch clears the flag for good
  task automatic t_check;
    hits = 0;
    good = 0;
    for (int c = 0; c < 8; c++) begin
      do_reset();
      code <= 3'(c);
      lock <= 1'b1;
      st();
      if (ok_n === 1'b1) begin
        hits++;
        good = c;
      end
    end
    chk(hits, 1);
    do_reset();
    code <= 3'(good);
    lock <= 1'b1;
    pucs_ecu_model_inst.wr(ADDR_DAY, 8'h0f);
    pucs_ecu_model_inst.rd(ADDR_DAY, v);
    chk(v, 9'h100);
    @(posedge clk_sys_in);
    lb <= lb ^ 8'h80;
    st();
    chk(ok_n, 1'b1);
    @(posedge clk_sys_in);
    mk <= mk ^ 8'h01;
    st();
    chk(ok_n, 1'b0);
    @(posedge clk_sys_in);
    mk <= mk ^ 8'h01;
    st();
    chk(ok_n, 1'b0);
    pucs_ecu_model_inst.rd(ADDR_STATUS, v);
    chk(v[4], 1'b0);
    do_reset();
    code <= 3'(good + 1);
    lock <= 1'b0;
    st();
    chk(ok_n, 1'b1);
    $display("check test done");
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    t_reset();
    t_modes();
    t_slots();
    t_ident();
    t_status();
    t_check();
    results();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
